/* File: inc/bbs_pkg.sv */
/*
 * Shared constants and types for the branch and bit-set execute block.
 * Assumes a single core clock; instruction cycles are four quarter phases.
 */
package bbs_pkg;

   // ****************************************************************
   // Instruction encodings
   // ****************************************************************
   localparam logic [7:0] BBS_OPC_BOV      = 8'he4;
   localparam logic [7:0] BBS_OPC_BNZ      = 8'he1;
   localparam logic [4:0] BBS_OPC_BRA      = 5'h1a;
   localparam logic [3:0] BBS_OPC_BSF      = 4'h8;
   localparam int         BBS_BRA_OFF_W    = 11;
   localparam int         BBS_BCC_OFF_W    = 8;
   localparam int         BBS_F_W          = 8;
   localparam int         BBS_BIT_LSB      = 9;
   localparam int         BBS_A_POS        = 8;
   // Highest file address that switches to indexed literal offset mode
   localparam logic [7:0] BBS_ILO_F_MAX    = 8'h5f;

   // ****************************************************************
   // Quarter phases and control states
   // ****************************************************************
   localparam int BBS_NQ = 4;

   typedef enum logic [3:0] {
      QP_1 = 4'b0001,
      QP_2 = 4'b0010,
      QP_3 = 4'b0100,
      QP_4 = 4'b1000
   } bbs_qph_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_NOP = 2'b10
   } bbs_state_t;

   typedef enum logic [4:0] {
      OP_NONE = 5'b00001,
      OP_BOV  = 5'b00010,
      OP_BNZ  = 5'b00100,
      OP_BRA  = 5'b01000,
      OP_BSF  = 5'b10000
   } bbs_op_t;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      bbs_op_t           op;
      logic [10:0]       off;
      logic [2:0]        bitn;
      logic              a;
      logic [7:0]        f;
   } bbs_dec_t;

   localparam bbs_dec_t BBS_DEC_RST = '{op: OP_NONE, off: 11'h000, bitn: 3'h0, a: 1'b0, f: 8'h00};

endpackage

/* File: rtl/bbs_qphase.sv */
/*
 * Quarter-phase sequencer: one-hot Q1..Q4 rotating on the core clock.
 * Assumes the clock enable freezes it together with the rest of the core.
 */
`timescale 1ns/1ps
module bbs_qphase
   import bbs_pkg::*;
(
   input  wire logic     i_clk,
   input  wire logic     i_rst_n,
   input  wire logic     i_ce,
   output bbs_qph_t      o_q
);

   bbs_qph_t q_r;
   bbs_qph_t q_nxt;

   always_comb begin
      unique case (q_r)
         QP_1: q_nxt = QP_2;
         QP_2: q_nxt = QP_3;
         QP_3: q_nxt = QP_4;
         QP_4: q_nxt = QP_1;
         default: q_nxt = QP_1;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         q_r <= QP_1;
      end else if (i_ce) begin
         q_r <= q_nxt;
      end
   end

   assign o_q = q_r;

endmodule

/* File: rtl/bbs_exec.sv */
/*
 * Decode and execute of the conditional/unconditional relative branches and
 * the single-bit set of a file register.
 * Assumes the fetch stage offers a word in Q1 with its incremented PC, the
 * status flags are valid in Q3, and data memory returns read data one
 * cycle after a read strobe.
 */
`timescale 1ns/1ps
module bbs_exec
   import bbs_pkg::*;
#(
   parameter int         PC_W      = 21,
   parameter int         BANK_W    = 6,
   // Bank that holds the upper half of the access bank
   parameter logic [5:0] ACC_HI_BANK = 6'h3f
) (
   input  wire logic                  I_CLK,
   input  wire logic                  I_RST_N,
   input  wire logic                  I_CE,
   input  wire logic                  I_INSTR_VALID,
   input  wire logic [15:0]           I_INSTR,
   input  wire logic [PC_W-1:0]       I_PC_INC,
   input  wire logic                  I_STATUS_Z,
   input  wire logic                  I_STATUS_OV,
   input  wire logic [BANK_W-1:0]     I_BANK_SEL,
   input  wire logic                  I_EXT_EN,
   input  wire logic [7:0]            I_MEM_RDATA,
   output logic                       O_INSTR_READY,
   output bbs_qph_t                   O_QPHASE,
   output logic                       O_PC_WE,
   output logic [PC_W-1:0]            O_PC_DATA,
   output logic                       O_FLUSH,
   output logic                       O_MEM_RE,
   output logic                       O_MEM_WE,
   output logic [BANK_W+7:0]          O_MEM_ADDR,
   output logic                       O_MEM_ILO,
   output logic [7:0]                 O_MEM_WDATA
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (PC_W < BBS_BRA_OFF_W + 2) begin : g_bad_pc
      $error("PC_W too narrow for the branch offset");
   end
   if (BANK_W != 6) begin : g_bad_bank
      $error("BANK_W must match ACC_HI_BANK width");
   end

   // ****************************************************************
   // Quarter phases
   // ****************************************************************
   bbs_qph_t q;

   bbs_qphase bbs_qphase_i (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_ce    (I_CE),
      .o_q     (q)
   );

   // ****************************************************************
   // Decode
   // ****************************************************************
   bbs_dec_t dec;
   logic     take_in;

   always_comb begin
      dec      = BBS_DEC_RST;
      dec.off  = I_INSTR[BBS_BRA_OFF_W-1:0];
      dec.bitn = I_INSTR[BBS_BIT_LSB+2:BBS_BIT_LSB];
      dec.a    = I_INSTR[BBS_A_POS];
      dec.f    = I_INSTR[BBS_F_W-1:0];
      if (I_INSTR[15:8] == BBS_OPC_BOV) begin
         dec.op = OP_BOV;
      end else if (I_INSTR[15:8] == BBS_OPC_BNZ) begin
         dec.op = OP_BNZ;
      end else if (I_INSTR[15:11] == BBS_OPC_BRA) begin
         dec.op = OP_BRA;
      end else if (I_INSTR[15:12] == BBS_OPC_BSF) begin
         dec.op = OP_BSF;
      end
   end

   // ****************************************************************
   // Execute state
   // ****************************************************************
   bbs_state_t          state_r,  state_nxt;
   bbs_dec_t            instr_r,  instr_nxt;
   logic [PC_W-1:0]     pcinc_r,  pcinc_nxt;
   logic [7:0]          rdata_r,  rdata_nxt;
   logic                pcwe_r,   pcwe_nxt;
   logic [PC_W-1:0]     pcd_r,    pcd_nxt;
   logic                flush_r,  flush_nxt;
   logic                re_r,     re_nxt;
   logic                we_r,     we_nxt;
   logic [BANK_W+7:0]   addr_r,   addr_nxt;
   logic                ilo_r,    ilo_nxt;
   logic [7:0]          wd_r,     wd_nxt;
   logic [PC_W-1:0]     off2;
   logic                taken;

   assign take_in = (q == QP_1) && (state_r == ST_RUN) && I_INSTR_VALID;

   // Doubled, sign-extended offset; short branches use only the low byte
   always_comb begin
      if (instr_r.op == OP_BRA) begin
         off2 = PC_W'({{(PC_W-BBS_BRA_OFF_W){instr_r.off[BBS_BRA_OFF_W-1]}}, instr_r.off} << 1);
      end else begin
         off2 = PC_W'({{(PC_W-BBS_BCC_OFF_W){instr_r.off[BBS_BCC_OFF_W-1]}},
                       instr_r.off[BBS_BCC_OFF_W-1:0]} << 1);
      end
   end

   always_comb begin
      unique case (instr_r.op)
         OP_BOV:  taken = I_STATUS_OV;
         OP_BNZ:  taken = !I_STATUS_Z;
         OP_BRA:  taken = 1'b1;
         default: taken = 1'b0;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      instr_nxt = instr_r;
      pcinc_nxt = pcinc_r;
      rdata_nxt = rdata_r;
      pcwe_nxt  = 1'b0;
      pcd_nxt   = pcd_r;
      flush_nxt = 1'b0;
      re_nxt    = 1'b0;
      we_nxt    = 1'b0;
      addr_nxt  = addr_r;
      ilo_nxt   = ilo_r;
      wd_nxt    = wd_r;
      unique case (q)
         QP_1: begin
            if (take_in) begin
               instr_nxt = dec;
               pcinc_nxt = I_PC_INC;
               if (dec.op == OP_BSF) begin
                  re_nxt  = 1'b1;
                  ilo_nxt = 1'b0;
                  if (dec.a) begin
                     addr_nxt = {I_BANK_SEL, dec.f};
                  end else if (dec.f <= BBS_ILO_F_MAX) begin
                     addr_nxt = {{BANK_W{1'b0}}, dec.f};
                     ilo_nxt  = I_EXT_EN;
                  end else begin
                     addr_nxt = {ACC_HI_BANK, dec.f};
                  end
               end
            end else if (state_r == ST_RUN) begin
               instr_nxt = BBS_DEC_RST;
            end
         end
         QP_2: begin
            // Read data lands at the start of Q3, one cycle behind the Q2 strobe
         end
         QP_3: begin
            if (state_r == ST_RUN) begin
               rdata_nxt = I_MEM_RDATA;
               if (taken) begin
                  pcwe_nxt  = 1'b1;
                  pcd_nxt   = pcinc_r + off2;
                  flush_nxt = 1'b1;
               end
               if (instr_r.op == OP_BSF) begin
                  we_nxt = 1'b1;
                  wd_nxt = I_MEM_RDATA | (8'h01 << instr_r.bitn);
               end
            end
         end
         QP_4: begin
            // A taken branch turns the next instruction cycle into a bubble
            if (state_r == ST_RUN && pcwe_r) begin
               state_nxt = ST_NOP;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_r <= ST_RUN;
         instr_r <= BBS_DEC_RST;
         pcinc_r <= '0;
         rdata_r <= 8'h00;
         pcwe_r  <= 1'b0;
         pcd_r   <= '0;
         flush_r <= 1'b0;
         re_r    <= 1'b0;
         we_r    <= 1'b0;
         addr_r  <= '0;
         ilo_r   <= 1'b0;
         wd_r    <= 8'h00;
      end else if (I_CE) begin
         state_r <= state_nxt;
         instr_r <= instr_nxt;
         pcinc_r <= pcinc_nxt;
         rdata_r <= rdata_nxt;
         pcwe_r  <= pcwe_nxt;
         pcd_r   <= pcd_nxt;
         flush_r <= flush_nxt;
         re_r    <= re_nxt;
         we_r    <= we_nxt;
         addr_r  <= addr_nxt;
         ilo_r   <= ilo_nxt;
         wd_r    <= wd_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign O_INSTR_READY = (q == QP_1) && (state_r == ST_RUN);
   assign O_QPHASE      = q;
   assign O_PC_WE       = pcwe_r;
   assign O_PC_DATA     = pcd_r;
   assign O_FLUSH       = flush_r;
   assign O_MEM_RE      = re_r;
   assign O_MEM_WE      = we_r;
   assign O_MEM_ADDR    = addr_r;
   assign O_MEM_ILO     = ilo_r;
   assign O_MEM_WDATA   = wd_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   sequence s_take_q3(bbs_op_t kind);
      (q == QP_3) && (state_r == ST_RUN) && (instr_r.op == kind) && I_CE;
   endsequence

   sequence s_bubble;
      (state_r == ST_NOP) && !O_INSTR_READY;
   endsequence

   // Last quarter of a running cycle that did not branch
   sequence s_run_q4;
      (q == QP_4) && (state_r == ST_RUN) && !O_PC_WE && I_CE;
   endsequence

   AST_BOV_DECODE: assert property (take_in && I_CE && I_INSTR[15:8] == BBS_OPC_BOV
                                    |=> instr_r.op == OP_BOV)
      else $error("overflow branch not decoded");
   AST_BNZ_DECODE: assert property (take_in && I_CE && I_INSTR[15:8] == BBS_OPC_BNZ
                                    |=> instr_r.op == OP_BNZ)
      else $error("not-zero branch not decoded");
   AST_BRA_DECODE: assert property (take_in && I_CE && I_INSTR[15:11] == BBS_OPC_BRA
                                    |=> instr_r.op == OP_BRA)
      else $error("unconditional branch not decoded");
   AST_BSF_DECODE: assert property (take_in && I_CE && I_INSTR[15:12] == BBS_OPC_BSF
                                    |=> instr_r.op == OP_BSF && O_MEM_RE)
      else $error("bit set not decoded");
   AST_TARGET: assert property (O_PC_WE |-> O_PC_DATA == PC_W'(pcinc_r + off2))
      else $error("branch target wrong");
   AST_PC_WE_Q4: assert property (O_PC_WE |-> q == QP_4)
      else $error("program counter written outside Q4");
   AST_BOV_TAKEN: assert property (s_take_q3(OP_BOV) ##0 I_STATUS_OV |=> O_PC_WE && q == QP_4)
      else $error("taken overflow branch missed Q4 write");
   AST_BOV_NOT_TAKEN: assert property (s_take_q3(OP_BOV) ##0 !I_STATUS_OV |=> !O_PC_WE && !O_MEM_WE)
      else $error("untaken overflow branch wrote in Q4");
   AST_BOV_ONE_CYCLE: assert property (s_take_q3(OP_BOV) ##0 !I_STATUS_OV ##1 s_run_q4 |=> O_INSTR_READY)
      else $error("untaken overflow branch took more than one cycle");
   AST_BNZ: assert property (s_take_q3(OP_BNZ) |=> O_PC_WE == !$past(I_STATUS_Z))
      else $error("not-zero branch decision wrong");
   AST_BNZ_ONE_CYCLE: assert property (s_take_q3(OP_BNZ) ##0 I_STATUS_Z ##1 s_run_q4 |=> O_INSTR_READY)
      else $error("untaken not-zero branch took more than one cycle");
   AST_BRA_TWO: assert property (s_take_q3(OP_BRA) ##1 I_CE |=> s_bubble)
      else $error("unconditional branch lacks second cycle");
   AST_BUBBLE: assert property (O_PC_WE && I_CE |=> s_bubble ##1 (!O_INSTR_READY)[*3])
      else $error("no bubble after taken branch");
   AST_FLUSH: assert property (O_PC_WE |-> O_FLUSH)
      else $error("prefetch not discarded");
   AST_BSF_WRITE: assert property (s_take_q3(OP_BSF) |=> O_MEM_WE && !O_PC_WE && q == QP_4)
      else $error("bit set missed its Q4 write");
   AST_MEM_RE_Q2: assert property (O_MEM_RE |-> q == QP_2)
      else $error("register read outside Q2");
   AST_BSF_DATA: assert property (O_MEM_WE |-> O_MEM_WDATA == (rdata_r | (8'h01 << instr_r.bitn)))
      else $error("bit set data wrong");
   AST_BANKED: assert property (O_MEM_RE && instr_r.a |-> O_MEM_ADDR[BANK_W+7:8] == $past(I_BANK_SEL))
      else $error("banked address wrong");
   AST_ACCESS_HI: assert property (O_MEM_RE && !instr_r.a && instr_r.f > BBS_ILO_F_MAX
                                   |-> O_MEM_ADDR == {ACC_HI_BANK, instr_r.f})
      else $error("upper access bank address wrong");
   AST_ILO: assert property (O_MEM_RE && !instr_r.a
                             |-> O_MEM_ILO == ($past(I_EXT_EN) && instr_r.f <= BBS_ILO_F_MAX))
      else $error("indexed literal offset flag wrong");

endmodule

/* File: testbench/bbs_dmem_model.sv */
/*
 * Data memory seen by the execute block: byte cells, read data one cycle
 * after the read strobe. Assumes the address is {bank, f} of ADDR_W bits.
 */
`timescale 1ns/1ps
module bbs_dmem_model #(
   parameter int ADDR_W = 14
) (
   input  wire logic              i_clk,
   input  wire logic              i_mem_re,
   input  wire logic              i_mem_we,
   input  wire logic [ADDR_W-1:0] i_mem_addr,
   input  wire logic [7:0]        i_mem_wdata,
   output logic      [7:0]        o_mem_rdata
);
   logic [7:0] mem [0:(1<<ADDR_W)-1];

   initial begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
         mem[i] = 8'(i) ^ 8'ha5;
      end
      o_mem_rdata = 8'h00;
   end

   always @(posedge i_clk) begin
      if (i_mem_re === 1'b1) begin
         o_mem_rdata <= mem[i_mem_addr];
      end else begin
         // Released bus toggles so a late sample never looks valid
         o_mem_rdata <= ~o_mem_rdata;
      end
      if (i_mem_we === 1'b1) begin
         mem[i_mem_addr] <= i_mem_wdata;
      end
   end
endmodule

/* File: testbench/branch_and_bit_set_exec_test.sv */
/*
 * Self-checking bench for the branch and bit-set execute block.
 * Assumes bbs_dmem_model on the memory side; the bench acts as fetch stage.
 */
`timescale 1ns/1ps
module branch_and_bit_set_exec_test
   import bbs_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n, ce, instr_valid, status_z, status_ov, ext_en;
   logic [15:0] instr;
   logic [20:0] pc_inc, pc_data, cap_pc;
   logic [5:0]  bank_sel;
   logic [7:0]  mem_rdata, mem_wdata, cap_wdata;
   logic        instr_ready, pc_we, flush, mem_re, mem_we, mem_ilo, cap_ilo;
   bbs_qph_t    qphase;
   logic [13:0] mem_addr, cap_addr;
   int          n_errors = 0;
   int          n_checks = 0;
   int          pc_we_k, flush_k, re_k, mwe_k, rdy_k;

   always #5 clk = ~clk;

   bbs_exec bbs_exec_i (
      .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_INSTR_VALID(instr_valid),
      .I_INSTR(instr), .I_PC_INC(pc_inc), .I_STATUS_Z(status_z), .I_STATUS_OV(status_ov),
      .I_BANK_SEL(bank_sel), .I_EXT_EN(ext_en), .I_MEM_RDATA(mem_rdata),
      .O_INSTR_READY(instr_ready), .O_QPHASE(qphase), .O_PC_WE(pc_we), .O_PC_DATA(pc_data),
      .O_FLUSH(flush), .O_MEM_RE(mem_re), .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr),
      .O_MEM_ILO(mem_ilo), .O_MEM_WDATA(mem_wdata));

   bbs_dmem_model bbs_dmem_model_i (
      .i_clk(clk), .i_mem_re(mem_re), .i_mem_we(mem_we), .i_mem_addr(mem_addr),
      .i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata));

   // ****************************************************************
   // Compare and closing tasks
   // ****************************************************************
   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Fetch driver: offer one word in Q1, log when each pulse shows
   // ****************************************************************
   task automatic wait_q1();
      int n;
      n = 0;
      while (!(qphase === QP_1 && instr_ready === 1'b1) && n < 16) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic run_instr(input logic [15:0] ins, input logic [20:0] pc, input logic z,
                            input logic ov, input logic [5:0] bank, input logic ext);
      wait_q1();
      {pc_we_k, flush_k, re_k, mwe_k, rdy_k} = '0;
      instr       = ins;
      pc_inc      = pc;
      status_z    = z;
      status_ov   = ov;
      bank_sel    = bank;
      ext_en      = ext;
      instr_valid = 1'b1;
      for (int k = 1; k <= 8; k++) begin
         @(negedge clk);
         if (k == 1) begin
            instr_valid = 1'b0;
         end
         if (pc_we === 1'b1) begin
            pc_we_k = k;
            cap_pc  = pc_data;
         end
         if (flush === 1'b1) begin
            flush_k = k;
         end
         if (mem_re === 1'b1) begin
            re_k     = k;
            cap_addr = mem_addr;
            cap_ilo  = mem_ilo;
         end
         if (mem_we === 1'b1) begin
            mwe_k     = k;
            cap_wdata = mem_wdata;
         end
         if (k >= 4 && instr_ready === 1'b1) begin
            rdy_k = k;
            break;
         end
      end
   endtask

   function automatic logic [20:0] tgt(input logic [20:0] pc, input logic signed [11:0] n);
      return pc + 21'(2 * n);
   endfunction

   task automatic check_branch(input logic taken, input logic [20:0] exp_pc);
      chk_val("pc_write_cycle", taken ? 3 : 0, pc_we_k);
      chk_val("flush_cycle", taken ? 3 : 0, flush_k);
      chk_val("ready_again", taken ? 8 : 4, rdy_k);
      chk_val("mem_strobes", 0, re_k + mwe_k);
      if (taken) begin
         chk_val("pc_target", {11'h0, exp_pc}, {11'h0, cap_pc});
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk_val("reset_phase", {28'h0, QP_1}, {28'h0, qphase});
      chk_bit("reset_ready", 1'b1, instr_ready);
      chk_val("reset_pulses", 0, {pc_we, flush, mem_re, mem_we});
      $display("test reset done");
   endtask

   task automatic t_branches();
      run_instr(16'he480, 21'h001000, 1'b1, 1'b1, 6'h00, 1'b0);
      check_branch(1'b1, tgt(21'h001000, 12'hf80));
      run_instr(16'he47f, 21'h1ffffe, 1'b0, 1'b1, 6'h00, 1'b0);
      check_branch(1'b1, tgt(21'h1ffffe, 12'h07f));
      run_instr(16'he47f, 21'h001000, 1'b1, 1'b0, 6'h00, 1'b0);
      check_branch(1'b0, 21'h0);
      run_instr(16'he1fe, 21'h002000, 1'b0, 1'b0, 6'h00, 1'b0);
      check_branch(1'b1, tgt(21'h002000, 12'hffe));
      run_instr(16'he101, 21'h002000, 1'b1, 1'b1, 6'h00, 1'b0);
      check_branch(1'b0, 21'h0);
      run_instr(16'hd400, 21'h004000, 1'b1, 1'b0, 6'h00, 1'b0);
      check_branch(1'b1, tgt(21'h004000, 12'hc00));
      run_instr(16'hd3ff, 21'h004000, 1'b0, 1'b1, 6'h00, 1'b0);
      check_branch(1'b1, tgt(21'h004000, 12'h3ff));
      $display("test branches done");
   endtask

   task automatic t_foreign();
      run_instr(16'hd800, 21'h000400, 1'b0, 1'b0, 6'h00, 1'b0);
      check_branch(1'b0, 21'h0);
      run_instr(16'he5ff, 21'h000400, 1'b0, 1'b0, 6'h00, 1'b0);
      check_branch(1'b0, 21'h0);
      run_instr(16'h9e10, 21'h000400, 1'b0, 1'b0, 6'h00, 1'b0);
      check_branch(1'b0, 21'h0);
      $display("test foreign done");
   endtask

   task automatic t_bsf_one(input logic [2:0] b, input logic a, input logic [5:0] bank,
                            input logic ext, input logic [7:0] f, input logic [13:0] exp_addr,
                            input logic exp_ilo);
      logic [7:0] exp_d;
      exp_d = bbs_dmem_model_i.mem[exp_addr] | (8'h01 << b);
      run_instr({4'h8, b, a, f}, 21'h000200, 1'b0, 1'b0, bank, ext);
      chk_val("mem_read_cycle", 1, re_k);
      chk_val("mem_write_cycle", 3, mwe_k);
      chk_val("pc_write_cycle", 0, pc_we_k);
      chk_val("ready_again", 4, rdy_k);
      chk_val("mem_addr", {18'h0, exp_addr}, {18'h0, cap_addr});
      chk_bit("mem_ilo", exp_ilo, cap_ilo);
      chk_val("mem_wdata", {24'h0, exp_d}, {24'h0, cap_wdata});
      chk_val("mem_cell", {24'h0, exp_d}, {24'h0, bbs_dmem_model_i.mem[exp_addr]});
   endtask

   task automatic t_bsf();
      t_bsf_one(3'h0, 1'b1, 6'h15, 1'b1, 8'h3c, 14'h153c, 1'b0);
      t_bsf_one(3'h1, 1'b1, 6'h2a, 1'b1, 8'h10, 14'h2a10, 1'b0);
      t_bsf_one(3'h2, 1'b0, 6'h15, 1'b1, 8'h5f, 14'h005f, 1'b1);
      t_bsf_one(3'h3, 1'b0, 6'h15, 1'b1, 8'h60, 14'h3f60, 1'b0);
      t_bsf_one(3'h4, 1'b0, 6'h15, 1'b0, 8'h00, 14'h0000, 1'b0);
      t_bsf_one(3'h5, 1'b0, 6'h15, 1'b0, 8'hff, 14'h3fff, 1'b0);
      t_bsf_one(3'h6, 1'b1, 6'h01, 1'b0, 8'hff, 14'h01ff, 1'b0);
      t_bsf_one(3'h7, 1'b0, 6'h2a, 1'b1, 8'h00, 14'h0000, 1'b1);
      $display("test bsf done");
   endtask

   task automatic t_freeze();
      wait_q1();
      instr       = 16'hd001;
      pc_inc      = 21'h000300;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      ce          = 1'b0;
      repeat (3) begin
         @(negedge clk);
         chk_val("frozen_phase", {28'h0, QP_2}, {28'h0, qphase});
         chk_bit("frozen_pc_we", 1'b0, pc_we);
      end
      ce = 1'b1;
      repeat (2) @(negedge clk);
      chk_bit("thaw_pc_we", 1'b1, pc_we);
      chk_val("thaw_pc", 32'h302, {11'h0, pc_data});
      $display("test freeze done");
   endtask

   // Reset in mid-instruction must abandon the branch already taken in
   task automatic t_reset_mid();
      wait_q1();
      instr       = 16'hd001;
      pc_inc      = 21'h000500;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      rst_n       = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      repeat (3) begin
         @(negedge clk);
         chk_bit("reset_abandons_pc_we", 1'b0, pc_we);
         chk_bit("reset_abandons_flush", 1'b0, flush);
      end
      $display("test reset_mid done");
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      {rst_n, instr_valid, status_z, status_ov, ext_en} = '0;
      ce       = 1'b1;
      instr    = 16'h0000;
      pc_inc   = 21'h0;
      bank_sel = 6'h00;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_branches();
      t_foreign();
      t_bsf();
      t_freeze();
      t_reset_mid();
      wait_q1();
      end_sim();
   end

   // Whole run is about 120 cycles; this leaves wide margin
   initial begin
      #100000;
      n_errors++;
      $display("[FAIL] watchdog expected finish seen timeout");
      end_sim();
   end
endmodule
